// File: include/phy_mgmt_pkg.sv
// Constants, field layouts and carrier types for the transceiver management register bank.
package phy_mgmt_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [5:0] IDX_CONTROL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_ID_HIGH = 6'h02;
    localparam logic [5:0] IDX_ID_LOW = 6'h03;
    localparam logic [5:0] IDX_ADVERTISE = 6'h04;
    localparam logic [5:0] IDX_PARTNER = 6'h05;
    localparam logic [5:0] IDX_EXPANSION = 6'h06;
    localparam logic [5:0] IDX_NEXT_PAGE = 6'h07;
    localparam logic [5:0] IDX_PARTNER_NP = 6'h08;
    localparam logic [5:0] IDX_RXER_COUNT = 6'h15;
    localparam logic [5:0] IDX_INTR_CTRL = 6'h1B;
    localparam logic [5:0] IDX_FAST_CTRL = 6'h1F;

    // ------------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------------
    localparam int unsigned CTL_RESET = 15;
    localparam int unsigned CTL_LOOPBACK = 14;
    localparam int unsigned CTL_SPEED = 13;
    localparam int unsigned CTL_AN_EN = 12;
    localparam int unsigned CTL_POWER_DOWN = 11;
    localparam int unsigned CTL_ISOLATE = 10;
    localparam int unsigned CTL_AN_RESTART = 9;
    localparam int unsigned CTL_DUPLEX = 8;
    localparam int unsigned CTL_COL_TEST = 7;
    localparam int unsigned CTL_TX_DISABLE = 0;

    // ------------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------------
    localparam int unsigned STS_AN_COMPLETE = 5;
    localparam int unsigned STS_REMOTE_FAULT = 4;
    localparam int unsigned STS_LINK = 2;
    localparam int unsigned STS_JABBER = 1;
    localparam logic [15:0] STATUS_FIXED = 16'h7849;
    localparam logic [15:0] STATUS_CONST_MASK = 16'hFFC9;

    // ------------------------------------------------------------------
    // Identifier values (arbitrary neutral values)
    // ------------------------------------------------------------------
    localparam logic [15:0] OUI_HIGH_BITS = 16'h1234;
    localparam logic [5:0] OUI_LOW_BITS = 6'h2A;
    localparam logic [5:0] MODEL_NUMBER = 6'h15;
    localparam logic [3:0] REVISION_NUMBER = 4'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 10;
    localparam int unsigned SOFT_RESET_NS = 1000;
    localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STRAP_SETTLE_CYCLES = 2;
    localparam int unsigned CNT_W = 4;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic autoneg_en;
        logic power_down;
        logic isolate;
        logic full_duplex;
        logic col_test;
        logic tx_disable;
    } ctrl_t;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic autoneg_en;
        logic power_down;
        logic isolate;
        logic full_duplex;
        logic col_test;
        logic tx_disable;
        logic an_restart;
        logic phy_reset;
    } phy_mode_t;

    typedef struct packed {
        logic speed_strap;
        logic autoneg_strap;
        logic isolate_strap;
        logic duplex_strap;
    } strap_t;

    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
        logic an_complete;
        logic an_speed_100;
        logic an_full_duplex;
    } line_status_t;

endpackage : phy_mgmt_pkg

// File: design/phy_mgmt_regs.sv
// Management register bank of a 10/100 transceiver, reached over APB.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module phy_mgmt_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [phy_mgmt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire phy_mgmt_pkg::strap_t straps,
    input wire phy_mgmt_pkg::line_status_t line_status,
    output phy_mgmt_pkg::phy_mode_t mode
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [15:0] ctrl_word(input phy_mgmt_pkg::ctrl_t c, input logic busy,
                                             input logic restart);
        logic [15:0] w;
        w = 16'h0000;
        w[phy_mgmt_pkg::CTL_RESET] = busy;
        w[phy_mgmt_pkg::CTL_LOOPBACK] = c.loopback;
        w[phy_mgmt_pkg::CTL_SPEED] = c.speed_100;
        w[phy_mgmt_pkg::CTL_AN_EN] = c.autoneg_en;
        w[phy_mgmt_pkg::CTL_POWER_DOWN] = c.power_down;
        w[phy_mgmt_pkg::CTL_ISOLATE] = c.isolate;
        w[phy_mgmt_pkg::CTL_AN_RESTART] = restart;
        w[phy_mgmt_pkg::CTL_DUPLEX] = c.full_duplex;
        w[phy_mgmt_pkg::CTL_COL_TEST] = c.col_test;
        w[phy_mgmt_pkg::CTL_TX_DISABLE] = c.tx_disable;
        return w;
    endfunction : ctrl_word

    function automatic phy_mgmt_pkg::ctrl_t strap_defaults(input phy_mgmt_pkg::strap_t s);
        phy_mgmt_pkg::ctrl_t c;
        c = '0;
        c.speed_100 = s.speed_strap;
        c.autoneg_en = s.autoneg_strap;
        c.isolate = s.isolate_strap;
        c.full_duplex = s.duplex_strap;
        return c;
    endfunction : strap_defaults

    function automatic logic addr_is(input logic [phy_mgmt_pkg::ADDR_W-1:0] a,
                                     input logic [5:0] idx);
        return (a[1:0] == 2'h0) && (a[phy_mgmt_pkg::ADDR_W-1:2] == idx);
    endfunction : addr_is

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    phy_mgmt_pkg::strap_t strap_meta_r;
    phy_mgmt_pkg::strap_t strap_s_r;
    phy_mgmt_pkg::line_status_t line_meta_r;
    phy_mgmt_pkg::line_status_t line_s_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_meta_r <= '0;
            strap_s_r <= '0;
            line_meta_r <= '0;
            line_s_r <= '0;
        end
        else
        begin
            strap_meta_r <= straps;
            strap_s_r <= strap_meta_r;
            line_meta_r <= line_status;
            line_s_r <= line_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Control sequencing
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_STRAP, ST_RUN, ST_SWRST} seq_state_t;

    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [phy_mgmt_pkg::CNT_W-1:0] cnt_r;
    logic [phy_mgmt_pkg::CNT_W-1:0] cnt_nxt;
    phy_mgmt_pkg::ctrl_t ctrl_r;
    phy_mgmt_pkg::ctrl_t ctrl_nxt;
    phy_mgmt_pkg::phy_mode_t mode_r;
    phy_mgmt_pkg::phy_mode_t mode_nxt;
    logic lat_rf_r;
    logic lat_rf_nxt;
    logic lat_jab_r;
    logic lat_jab_nxt;
    logic lat_link_r;
    logic lat_link_nxt;
    logic pready_r;
    logic pready_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic access;
    logic wr_ctrl;
    logic rd_status;
    logic [15:0] cur_ctrl;
    logic [15:0] merged;
    logic [15:0] status_word;

    always_comb
    begin
        access = psel && penable && pready_r;
        wr_ctrl = access && pwrite && addr_is(paddr, phy_mgmt_pkg::IDX_CONTROL);
        rd_status = psel && !penable && !pwrite && addr_is(paddr, phy_mgmt_pkg::IDX_STATUS);
        cur_ctrl = ctrl_word(ctrl_r, 1'b0, 1'b0);
        merged[15:8] = pstrb[1] ? pwdata[15:8] : cur_ctrl[15:8];
        merged[7:0] = pstrb[0] ? pwdata[7:0] : cur_ctrl[7:0];
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ctrl_nxt = ctrl_r;
        mode_nxt = '0;
        case (state_r)
            ST_STRAP:
            begin
                // Straps are taken only once both synchroniser stages hold them.
                if (cnt_r == phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::STRAP_SETTLE_CYCLES))
                begin
                    ctrl_nxt = strap_defaults(strap_s_r);
                    state_nxt = ST_RUN;
                    cnt_nxt = '0;
                end
                else
                begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_RUN:
            begin
                if (wr_ctrl && merged[phy_mgmt_pkg::CTL_RESET])
                begin
                    state_nxt = ST_SWRST;
                    cnt_nxt = '0;
                end
                else if (wr_ctrl)
                begin
                    ctrl_nxt.loopback = merged[phy_mgmt_pkg::CTL_LOOPBACK];
                    ctrl_nxt.speed_100 = merged[phy_mgmt_pkg::CTL_SPEED];
                    ctrl_nxt.autoneg_en = merged[phy_mgmt_pkg::CTL_AN_EN];
                    ctrl_nxt.power_down = merged[phy_mgmt_pkg::CTL_POWER_DOWN];
                    ctrl_nxt.isolate = merged[phy_mgmt_pkg::CTL_ISOLATE];
                    ctrl_nxt.full_duplex = merged[phy_mgmt_pkg::CTL_DUPLEX];
                    ctrl_nxt.col_test = merged[phy_mgmt_pkg::CTL_COL_TEST];
                    ctrl_nxt.tx_disable = merged[phy_mgmt_pkg::CTL_TX_DISABLE];
                    mode_nxt.an_restart = merged[phy_mgmt_pkg::CTL_AN_RESTART];
                end
            end
            ST_SWRST:
            begin
                // Control writes are dropped while the reset runs.
                if (cnt_r == phy_mgmt_pkg::CNT_W'(phy_mgmt_pkg::SOFT_RESET_CYCLES - 1))
                begin
                    ctrl_nxt = strap_defaults(strap_s_r);
                    state_nxt = ST_RUN;
                    cnt_nxt = '0;
                end
                else
                begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_STRAP;
                cnt_nxt = '0;
            end
        endcase
        mode_nxt.loopback = ctrl_nxt.loopback;
        mode_nxt.autoneg_en = ctrl_nxt.autoneg_en;
        mode_nxt.power_down = ctrl_nxt.power_down;
        mode_nxt.isolate = ctrl_nxt.isolate;
        mode_nxt.col_test = ctrl_nxt.col_test;
        mode_nxt.tx_disable = ctrl_nxt.tx_disable;
        mode_nxt.phy_reset = (state_nxt != ST_RUN);
        mode_nxt.speed_100 = ctrl_nxt.autoneg_en ? line_s_r.an_speed_100
                                                  : ctrl_nxt.speed_100;
        mode_nxt.full_duplex = ctrl_nxt.autoneg_en ? line_s_r.an_full_duplex
                                                    : ctrl_nxt.full_duplex;
    end

    // ------------------------------------------------------------------
    // Latched status
    // ------------------------------------------------------------------
    always_comb
    begin
        // Latches reload as the read word is captured, and a fresh event then still wins.
        lat_rf_nxt = (rd_status ? 1'b0 : lat_rf_r) | line_s_r.remote_fault;
        lat_jab_nxt = (rd_status ? 1'b0 : lat_jab_r) | line_s_r.jabber;
        lat_link_nxt = rd_status ? line_s_r.link_up : (lat_link_r & line_s_r.link_up);
        if (state_r != ST_RUN)
        begin
            lat_rf_nxt = 1'b0;
            lat_jab_nxt = 1'b0;
            lat_link_nxt = 1'b0;
        end
        status_word = phy_mgmt_pkg::STATUS_FIXED;
        status_word[phy_mgmt_pkg::STS_AN_COMPLETE] = line_s_r.an_complete
                                                     && (state_r == ST_RUN);
        status_word[phy_mgmt_pkg::STS_REMOTE_FAULT] = lat_rf_r;
        status_word[phy_mgmt_pkg::STS_LINK] = lat_link_r;
        status_word[phy_mgmt_pkg::STS_JABBER] = lat_jab_r;
    end

    // ------------------------------------------------------------------
    // APB slave, no wait states; read data leaves a flip-flop loaded in the setup cycle
    // ------------------------------------------------------------------
    always_comb
    begin
        pready_nxt = psel && !penable;
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (pready_nxt)
        begin
            if (addr_is(paddr, phy_mgmt_pkg::IDX_CONTROL))
            begin
                prdata_nxt[15:0] = ctrl_word(ctrl_r, state_r != ST_RUN,
                                             mode_r.an_restart);
            end
            else if (addr_is(paddr, phy_mgmt_pkg::IDX_STATUS))
            begin
                prdata_nxt[15:0] = status_word;
            end
            else if (addr_is(paddr, phy_mgmt_pkg::IDX_ID_HIGH))
            begin
                prdata_nxt[15:0] = phy_mgmt_pkg::OUI_HIGH_BITS;
            end
            else if (addr_is(paddr, phy_mgmt_pkg::IDX_ID_LOW))
            begin
                prdata_nxt[15:0] = {phy_mgmt_pkg::OUI_LOW_BITS, phy_mgmt_pkg::MODEL_NUMBER,
                                    phy_mgmt_pkg::REVISION_NUMBER};
            end
            else if (addr_is(paddr, phy_mgmt_pkg::IDX_ADVERTISE)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_PARTNER)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_EXPANSION)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_NEXT_PAGE)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_PARTNER_NP)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_RXER_COUNT)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_INTR_CTRL)
                     || addr_is(paddr, phy_mgmt_pkg::IDX_FAST_CTRL))
            begin
                // These registers live outside this bank and read as zero here.
                prdata_nxt = 32'h0000_0000;
            end
            else
            begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_STRAP;
            cnt_r <= '0;
            ctrl_r <= '0;
            mode_r <= '0;
            lat_rf_r <= 1'b0;
            lat_jab_r <= 1'b0;
            lat_link_r <= 1'b0;
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
            lat_rf_r <= lat_rf_nxt;
            lat_jab_r <= lat_jab_nxt;
            lat_link_r <= lat_link_nxt;
            pready_r <= pready_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign mode = mode_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_soft_reset;
        (state_r == ST_RUN) && wr_ctrl && merged[phy_mgmt_pkg::CTL_RESET]
            |=> mode_r.phy_reset[*8] ##[1:4] !mode_r.phy_reset;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset length wrong");

    property p_restart_pulse;
        (state_r == ST_RUN) && wr_ctrl && !merged[phy_mgmt_pkg::CTL_RESET]
            && merged[phy_mgmt_pkg::CTL_AN_RESTART]
            |=> mode_r.an_restart ##1 !mode_r.an_restart;
    endproperty
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart not a pulse");

    property p_speed_select;
        mode_r.speed_100 == (ctrl_r.autoneg_en ? $past(line_s_r.an_speed_100)
                                               : ctrl_r.speed_100);
    endproperty
    a_speed_select: assert property (p_speed_select) else $error("speed source wrong");

    property p_duplex_select;
        mode_r.full_duplex == (ctrl_r.autoneg_en ? $past(line_s_r.an_full_duplex)
                                                 : ctrl_r.full_duplex);
    endproperty
    a_duplex_select: assert property (p_duplex_select) else $error("duplex source wrong");

    property p_fault_latch;
        (lat_rf_r || line_s_r.remote_fault) && !rd_status && (state_r == ST_RUN)
            |=> lat_rf_r;
    endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("remote fault lost");

    property p_link_latch;
        !lat_link_r && !rd_status |=> !lat_link_r;
    endproperty
    a_link_latch: assert property (p_link_latch) else $error("link low not held");

    property p_status_const;
        psel && penable && pready_r && !pwrite && addr_is(paddr, phy_mgmt_pkg::IDX_STATUS)
            |-> ((prdata_r[15:0] & phy_mgmt_pkg::STATUS_CONST_MASK) == phy_mgmt_pkg::STATUS_FIXED)
                && (prdata_r[31:16] == 16'h0000);
    endproperty
    a_status_const: assert property (p_status_const) else $error("status constants wrong");

    property p_ctrl_reserved;
        psel && penable && pready_r && !pwrite && addr_is(paddr, phy_mgmt_pkg::IDX_CONTROL)
            |-> (prdata_r[6:1] == 6'h00);
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits set");

    property p_id_high;
        psel && penable && pready_r && !pwrite && addr_is(paddr, phy_mgmt_pkg::IDX_ID_HIGH)
            |-> (prdata_r == {16'h0000, phy_mgmt_pkg::OUI_HIGH_BITS});
    endproperty
    a_id_high: assert property (p_id_high) else $error("identifier read wrong");

endmodule : phy_mgmt_regs

// File: verification/tb.sv
// Self-checking testbench for the transceiver management register bank.
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------------
    localparam logic [15:0] CTL_DEF = 16'h2100;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    phy_mgmt_pkg::strap_t straps = 4'h9;
    phy_mgmt_pkg::line_status_t ls = 6'h00;
    phy_mgmt_pkg::phy_mode_t mode;
    logic [32:0] exp_q[$];
    logic [15:0] seed = 16'h896F;
    logic [15:0] w;
    int fail_count = 0;
    int cmp_count = 0;

    always #50 pclk = ~pclk;

    phy_mgmt_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .straps(straps), .line_status(ls), .mode(mode));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] xorshift();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction : xorshift

    function automatic logic [32:0] sts(input logic lk, input logic rf, input logic jb,
                                        input logic an);
        return {17'h0_0000, 16'h7849 | {10'h000, an, rf, 1'b0, lk, jb, 1'b0}};
    endfunction : sts

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // One APB transfer; the read expectation is queued for the watcher.
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] data,
                       input logic [32:0] exp);
        int n;
        @(posedge pclk);
        if (!wr)
            exp_q.push_back(exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {xorshift(), data};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
            fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ------------------------------------------------------------------
    // Watcher: compares each completed read with the oldest note
    // ------------------------------------------------------------------
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front());

    initial
    begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, phy_mgmt_pkg::IDX_CONTROL, 16'h0000, {17'h0_0000, CTL_DEF});
        apb(1'b0, phy_mgmt_pkg::IDX_STATUS, 16'h0000, sts(0, 0, 0, 0));
        apb(1'b1, phy_mgmt_pkg::IDX_ID_HIGH, 16'h0000, 33'h0);
        apb(1'b1, phy_mgmt_pkg::IDX_STATUS, 16'hFFFF, 33'h0);
        apb(1'b0, phy_mgmt_pkg::IDX_ID_HIGH, 16'h0000,
            {17'h0_0000, phy_mgmt_pkg::OUI_HIGH_BITS});
        apb(1'b0, phy_mgmt_pkg::IDX_ID_LOW, 16'h0000, {17'h0_0000, phy_mgmt_pkg::OUI_LOW_BITS,
            phy_mgmt_pkg::MODEL_NUMBER, phy_mgmt_pkg::REVISION_NUMBER});
        apb(1'b0, 6'h09, 16'h0000, {1'b1, 32'h0000_0000});
        $display("test reset_and_identity done");
        // All writable bits first, then random values; the reset bit is left out here.
        for (int i = 0; i < 6; i++)
        begin
            w = (i == 0) ? 16'h7FFF : (xorshift() & 16'h7FFF);
            ls.an_speed_100 <= w[1];
            ls.an_full_duplex <= w[2];
            apb(1'b1, phy_mgmt_pkg::IDX_CONTROL, w, 33'h0);
            #1;
            check({32'h0, mode.an_restart}, {32'h0, w[9]});
            repeat (3) @(posedge pclk);
            #1;
            check({27'h0, mode.loopback, mode.autoneg_en, mode.power_down, mode.isolate,
                mode.col_test, mode.tx_disable},
                {27'h0, w[14], w[12], w[11], w[10], w[7], w[0]});
            check({31'h0, mode.speed_100, mode.full_duplex}, {31'h0,
                w[12] ? w[1] : w[13], w[12] ? w[2] : w[8]});
            apb(1'b0, phy_mgmt_pkg::IDX_CONTROL, 16'h0000, {17'h0_0000, w & 16'h7D81});
        end
        // Only the low byte lane is enabled, so the upper control bits must survive.
        pstrb <= 4'h1;
        apb(1'b1, phy_mgmt_pkg::IDX_CONTROL, 16'h0000, 33'h0);
        pstrb <= 4'hF;
        apb(1'b0, phy_mgmt_pkg::IDX_CONTROL, 16'h0000, {17'h0_0000, w & 16'h7D00});
        $display("test control_bits done");
        ls.an_complete <= 1'b1;
        ls.link_up <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, phy_mgmt_pkg::IDX_STATUS, 16'h0000, sts(0, 0, 0, 1));
        apb(1'b0, phy_mgmt_pkg::IDX_STATUS, 16'h0000, sts(1, 0, 0, 1));
        ls.link_up <= 1'b0;
        ls.remote_fault <= 1'b1;
        ls.jabber <= 1'b1;
        repeat (3) @(posedge pclk);
        ls.link_up <= 1'b1;
        ls.remote_fault <= 1'b0;
        ls.jabber <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, phy_mgmt_pkg::IDX_STATUS, 16'h0000, sts(0, 1, 1, 1));
        apb(1'b0, phy_mgmt_pkg::IDX_STATUS, 16'h0000, sts(1, 0, 0, 1));
        $display("test latched_status done");
        // The software reset must wipe the control state written as 16'h7FFF back to the strap defaults.
        apb(1'b1, phy_mgmt_pkg::IDX_CONTROL, 16'h7FFF, 33'h0);
        apb(1'b1, phy_mgmt_pkg::IDX_CONTROL, 16'h8000, 33'h0);
        // A control write while the reset runs must be dropped.
        apb(1'b1, phy_mgmt_pkg::IDX_CONTROL, 16'h4000, 33'h0);
        repeat (phy_mgmt_pkg::SOFT_RESET_CYCLES - 4) @(posedge pclk);
        #1;
        check({32'h0, mode.phy_reset}, 33'h1);
        repeat (1) @(posedge pclk);
        #1;
        check({32'h0, mode.phy_reset}, 33'h0);
        apb(1'b0, phy_mgmt_pkg::IDX_CONTROL, 16'h0000, {17'h0_0000, CTL_DEF});
        $display("test software_reset done");
        repeat (2) @(posedge pclk);
        final_report();
    end
endmodule : tb
